//--- tag_port_map.svh
`ifndef TAG_PORT_MAP_SVH
`define TAG_PORT_MAP_SVH

// Command codes.
`define CODE_QUERY        8'h28
`define CODE_ANSWER_OK    8'hf8
`define CODE_ANSWER_ERR   8'he8
`define CODE_REG_READ     8'h68
`define CODE_REG_WRITE    8'h78

// irq_source_select bit positions in hw_config_word.
`define SEL_FIELD_EN      0
`define SEL_RF_SRC        1
`define SEL_RF_EN         2

// Register-write data byte bit positions.
`define REGISTER_WRITE_CMD_RESET_REQ    0
`define REGISTER_WRITE_CMD_RF_STOP      4
`define REGISTER_WRITE_CMD_MASK_FIELD   5
`define REGISTER_WRITE_CMD_MASK_RF      6

// Register-read data byte bit positions.
`define REGISTER_READ_CMD_BCC_ERR      0
`define REGISTER_READ_CMD_FIELD_SEEN   3

// Low nibble of the status byte (command_result_field).
`define RES_OK            4'h0
`define RES_ERROR         4'h1
`define RES_BUSY          4'h7
`define RES_SELF_DIAG     4'hb

// Query response start address flags.
`define QADDR_TUNNEL_BIT  6

// Wait-limit tick: 1000 us at 20 MHz.
`define TICK_US           1000
`define CLK_MHZ           20
`define TICK_CYCLES       (`TICK_US * `CLK_MHZ)

`endif

//--- tag_port_pkg.sv
package tag_port_pkg;
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX, S_TX_ACK, S_TX_NEXT
    } bus_state_t;
    typedef enum logic [1:0] {C_IDLE, C_BUSY, C_READY} cmd_state_t;
    typedef enum logic [1:0] {RESP_STATUS, RESP_REG, RESP_QUERY} resp_kind_t;
    typedef enum logic [2:0] {
        T_IDLE, T_WAIT_QUERY, T_QUERY_RESP, T_WAIT_ANSWER, T_ANSWER_RESP
    } tunnel_state_t;
endpackage : tag_port_pkg

//--- sync_two_flop.sv
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : sync_two_flop
`default_nettype wire

//--- rfid_host_irq_tunnel_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "tag_port_map.svh"
module rfid_host_irq_tunnel_port
    import tag_port_pkg::*;
#(
    parameter logic [6:0]  SLAVE_ADDR  = 7'h2a,
    parameter logic [3:0]  STATUS_HIGH = 4'h0,
    parameter int          TICK_CYC    = `TICK_CYCLES
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_out,
    output logic             o_sda_oe_n,
    output logic             o_irq_low_out_n,
    input  wire logic [2:0]  i_hw_config_word,
    input  wire logic [7:0]  i_query_wait_limit,
    input  wire logic [7:0]  i_answer_wait_limit,
    input  wire logic        i_contact_supply,
    input  wire logic        i_field_present,
    input  wire logic        i_rf_resp_start,
    input  wire logic        i_rf_nvm_done,
    input  wire logic        i_rf_busy,
    input  wire logic        i_self_diag_err,
    input  wire logic        i_bcc_error,
    input  wire logic        i_tunnel_mode,
    input  wire logic        i_tunnel_cmd,
    input  wire logic [1:0]  i_tunnel_sec,
    input  wire logic [11:0] i_tunnel_addr,
    input  wire logic [7:0]  i_tunnel_len,
    input  wire logic [7:0]  i_tunnel_data,
    input  wire logic        i_proc_done,
    input  wire logic [3:0]  i_proc_result,
    output logic [7:0]       o_rx_byte,
    output logic             o_rx_valid,
    output logic             o_cmd_start,
    output logic             o_tunnel_rd,
    output logic             o_tunnel_reply,
    output logic             o_tunnel_reply_ok,
    output logic             o_tunnel_abort,
    output logic             o_rf_stop,
    output logic             o_reset_req
);
    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and bus condition detection.
    logic [3:0] sync_w;
    logic       scl_s, sda_s, field_s, contact_s;
    logic       scl_p_q, sda_p_q, field_p_q;

    sync_two_flop #(.W(4)) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async ({i_scl, i_sda, i_field_present, i_contact_supply}),
        .o_sync  (sync_w)
    );
    assign {scl_s, sda_s, field_s, contact_s} = sync_w;

    wire scl_rise   = scl_s & ~scl_p_q;
    wire scl_fall   = ~scl_s & scl_p_q;
    wire start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_cond  = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire field_rise = field_s & ~field_p_q;
    wire field_fall = ~field_s & field_p_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial slave state.
    bus_state_t    bus_q;
    logic [7:0]    sh_q, tx_sh_q;
    logic [2:0]    bit_q;
    logic          rw_q, ack_q, oe_n_q;
    logic [7:0]    rx_cnt_q, tx_idx_q;
    logic [7:0]    code_q, arg_q;
    logic          wr_end_q;

    cmd_state_t    cmd_q;
    resp_kind_t    resp_q;
    tunnel_state_t tun_q;
    logic [3:0]    result_q;
    logic          after_reg_q, reset_pend_q;
    logic [2:0]    mask_q;
    logic          irq_pend_q;
    logic [14:0]   tick_q;
    logic [7:0]    wait_q;

    wire [7:0] rx_next  = {sh_q[6:0], sda_s};
    wire       addr_hit = (bus_q == S_ADDR) && scl_rise && (bit_q == 3'h7)
                          && (sh_q[6:0] == SLAVE_ADDR);
    wire       rd_hit   = addr_hit && sda_s;
    wire       byte_in  = (bus_q == S_RX) && scl_rise && (bit_q == 3'h7);
    wire       rd_end   = rw_q && ((bus_q == S_TX_ACK && scl_rise && sda_s)
                          || (stop_cond && bus_q != S_IDLE && bus_q != S_ADDR));
    wire       wr_end   = stop_cond && !rw_q && (rx_cnt_q != 8'h00) && wr_end_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Response byte selection.
    wire [7:0] status_w = {STATUS_HIGH, result_q};
    wire [3:0] poll_res = (after_reg_q && i_self_diag_err) ? `RES_SELF_DIAG :
                          (after_reg_q && i_rf_busy) ? `RES_BUSY : result_q;
    wire [7:0] poll_w   = {STATUS_HIGH, poll_res};
    wire [7:0] reg_w    = {1'b0, mask_q[2], mask_q[1], o_rf_stop, field_s, 2'b00,
                           i_bcc_error};
    wire [7:0] qhi_w    = {1'b0, 1'b1, i_tunnel_sec, i_tunnel_addr[11:8]};
    wire [7:0] tx_byte  =
        (cmd_q != C_READY)                             ? poll_w :
        (tx_idx_q == 8'h00)                            ? status_w :
        (resp_q == RESP_REG && tx_idx_q == 8'h01)      ? reg_w :
        (resp_q == RESP_QUERY && tx_idx_q == 8'h01)    ? qhi_w :
        (resp_q == RESP_QUERY && tx_idx_q == 8'h02)    ? i_tunnel_addr[7:0] :
        (resp_q == RESP_QUERY && tx_idx_q == 8'h03)    ? i_tunnel_len :
        (resp_q == RESP_QUERY)                         ? i_tunnel_data :
                                                         status_w;

    ////////////////////////////////////////////////////////////////////////////////
    // Byte-level serial slave; acks its own address and every written byte.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            bus_q    <= S_IDLE;
            sh_q     <= 8'h00;
            tx_sh_q  <= 8'h00;
            bit_q    <= 3'h0;
            rw_q     <= 1'b0;
            ack_q    <= 1'b0;
            oe_n_q   <= 1'b1;
            rx_cnt_q <= 8'h00;
            tx_idx_q <= 8'h00;
            code_q   <= 8'h00;
            arg_q    <= 8'h00;
            wr_end_q <= 1'b0;
            scl_p_q  <= 1'b1;
            sda_p_q  <= 1'b1;
            field_p_q <= 1'b0;
        end else begin
            scl_p_q   <= scl_s;
            sda_p_q   <= sda_s;
            field_p_q <= field_s;
            if (start_cond) begin
                bus_q    <= S_ADDR;
                bit_q    <= 3'h0;
                oe_n_q   <= 1'b1;
                wr_end_q <= 1'b0;
            end else if (stop_cond) begin
                bus_q  <= S_IDLE;
                oe_n_q <= 1'b1;
            end else begin
                case (bus_q)
                    S_ADDR: if (scl_rise) begin
                        sh_q  <= rx_next;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            bus_q    <= addr_hit ? S_ADDR_ACK : S_IDLE;
                            rw_q     <= sda_s;
                            ack_q    <= 1'b0;
                            rx_cnt_q <= 8'h00;
                            tx_idx_q <= 8'h00;
                            wr_end_q <= addr_hit && !sda_s;
                        end
                    end
                    S_ADDR_ACK: if (scl_fall) begin
                        if (!ack_q) begin
                            ack_q  <= 1'b1;
                            oe_n_q <= 1'b0;
                        end else if (rw_q) begin
                            bus_q   <= S_TX;
                            tx_sh_q <= tx_byte;
                            oe_n_q  <= tx_byte[7];
                        end else begin
                            bus_q  <= S_RX;
                            oe_n_q <= 1'b1;
                        end
                    end
                    S_RX: if (scl_rise) begin
                        sh_q  <= rx_next;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            bus_q <= S_RX_ACK;
                            ack_q <= 1'b0;
                            if (rx_cnt_q == 8'h00) code_q <= rx_next;
                            if (rx_cnt_q == 8'h01) arg_q <= rx_next;
                            if (rx_cnt_q != 8'hff) rx_cnt_q <= rx_cnt_q + 8'h01;
                        end
                    end
                    S_RX_ACK: if (scl_fall) begin
                        ack_q  <= 1'b1;
                        oe_n_q <= ack_q;
                        if (ack_q) bus_q <= S_RX;
                    end
                    S_TX: if (scl_fall) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            bus_q  <= S_TX_ACK;
                            oe_n_q <= 1'b1;
                        end else begin
                            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                            oe_n_q  <= tx_sh_q[6];
                        end
                    end
                    S_TX_ACK: if (scl_rise) begin
                        bus_q <= sda_s ? S_IDLE : S_TX_NEXT;
                        if (!sda_s && tx_idx_q != 8'hff) tx_idx_q <= tx_idx_q + 8'h01;
                    end
                    S_TX_NEXT: if (scl_fall) begin
                        bus_q   <= S_TX;
                        tx_sh_q <= tx_byte;
                        oe_n_q  <= tx_byte[7];
                    end
                    default: bus_q <= S_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode, processing and response state.
    wire in_tunnel   = i_tunnel_mode;
    wire is_query    = (code_q == `CODE_QUERY);
    wire is_answer   = (code_q == `CODE_ANSWER_OK) || (code_q == `CODE_ANSWER_ERR);
    wire query_ok    = is_query && in_tunnel && (tun_q == T_WAIT_QUERY);
    wire answer_ok   = is_answer && in_tunnel && (tun_q == T_WAIT_ANSWER);
    wire local_cmd   = is_query || is_answer || (code_q == `CODE_REG_READ)
                       || (code_q == `CODE_REG_WRITE);
    wire tick        = (tick_q == 15'(TICK_CYC - 1));
    wire waiting     = (tun_q == T_WAIT_QUERY) || (tun_q == T_WAIT_ANSWER);
    wire [7:0] wait_lim = (tun_q == T_WAIT_QUERY) ? i_query_wait_limit : i_answer_wait_limit;
    wire timeout     = waiting && tick && (wait_q >= wait_lim);
    wire cmd_done    = (wr_end && local_cmd) || (cmd_q == C_BUSY && i_proc_done);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cmd_q        <= C_IDLE;
            resp_q       <= RESP_STATUS;
            result_q     <= `RES_OK;
            after_reg_q  <= 1'b0;
            mask_q       <= 3'h0;
            o_rf_stop    <= 1'b0;
            reset_pend_q <= 1'b0;
            o_reset_req  <= 1'b0;
            o_cmd_start  <= 1'b0;
        end else begin
            o_cmd_start <= wr_end && !local_cmd;
            o_reset_req <= 1'b0;
            if (wr_end) begin
                after_reg_q <= 1'b0;
                resp_q      <= RESP_STATUS;
                if (!local_cmd) begin
                    cmd_q <= C_BUSY;
                end else begin
                    cmd_q    <= C_READY;
                    result_q <= `RES_OK;
                    if (code_q == `CODE_REG_READ) resp_q <= RESP_REG;
                    if (code_q == `CODE_REG_WRITE) begin
                        mask_q       <= {arg_q[`REGISTER_WRITE_CMD_MASK_RF], arg_q[`REGISTER_WRITE_CMD_MASK_FIELD], 1'b0};
                        o_rf_stop    <= arg_q[`REGISTER_WRITE_CMD_RF_STOP];
                        reset_pend_q <= arg_q[`REGISTER_WRITE_CMD_RESET_REQ];
                    end
                    if (is_query) begin
                        if (query_ok) resp_q <= RESP_QUERY;
                        else result_q <= `RES_ERROR;
                    end
                    if (is_answer && !answer_ok) result_q <= `RES_ERROR;
                end
            end else if (cmd_q == C_BUSY && i_proc_done) begin
                cmd_q    <= C_READY;
                result_q <= i_proc_result;
            end else if (rd_end && cmd_q == C_READY) begin
                cmd_q        <= C_IDLE;
                after_reg_q  <= (resp_q == RESP_REG);
                o_reset_req  <= reset_pend_q;
                reset_pend_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt sources, masking and release; set wins over clear.
    wire rf_evt    = i_hw_config_word[`SEL_RF_SRC] ? i_rf_nvm_done : i_rf_resp_start;
    wire rf_irq    = i_hw_config_word[`SEL_RF_EN] && rf_evt && !mask_q[2];
    wire fld_irq   = i_hw_config_word[`SEL_FIELD_EN] && field_rise && !mask_q[1];
    wire pwr_irq   = !contact_s && field_rise;
    wire tun_irq   = in_tunnel && i_tunnel_cmd && (tun_q == T_IDLE);
    wire irq_set   = cmd_done || rf_irq || fld_irq || pwr_irq || tun_irq;
    wire irq_clr   = rd_hit || (!contact_s && field_fall);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_pend_q      <= 1'b0;
            o_irq_low_out_n <= 1'b1;
        end else begin
            irq_pend_q      <= irq_set | (irq_pend_q & ~irq_clr);
            o_irq_low_out_n <= ~(irq_set | (irq_pend_q & ~irq_clr));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tunnel exchange and wait-limit timers.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tun_q             <= T_IDLE;
            tick_q            <= 15'h0000;
            wait_q            <= 8'h00;
            o_tunnel_reply    <= 1'b0;
            o_tunnel_reply_ok <= 1'b0;
            o_tunnel_abort    <= 1'b0;
        end else begin
            o_tunnel_reply <= 1'b0;
            o_tunnel_abort <= 1'b0;
            tick_q         <= (tick || !waiting) ? 15'h0000 : tick_q + 15'h0001;
            if (tick && wait_q != 8'hff) wait_q <= wait_q + 8'h01;
            case (tun_q)
                T_IDLE: if (tun_irq) begin
                    tun_q  <= T_WAIT_QUERY;
                    wait_q <= 8'h00;
                end
                T_WAIT_QUERY: if (timeout || !in_tunnel) begin
                    tun_q          <= T_IDLE;
                    o_tunnel_abort <= 1'b1;
                end else if (wr_end && query_ok) begin
                    tun_q <= T_QUERY_RESP;
                end
                T_QUERY_RESP: if (rd_end && cmd_q == C_READY) begin
                    tun_q  <= T_WAIT_ANSWER;
                    tick_q <= 15'h0000;
                    wait_q <= 8'h00;
                end
                T_WAIT_ANSWER: if (timeout || !in_tunnel) begin
                    tun_q          <= T_IDLE;
                    o_tunnel_abort <= 1'b1;
                end else if (wr_end && answer_ok) begin
                    tun_q             <= T_ANSWER_RESP;
                    o_tunnel_reply_ok <= (code_q == `CODE_ANSWER_OK);
                end
                T_ANSWER_RESP: if (rd_end && cmd_q == C_READY) begin
                    tun_q          <= T_IDLE;
                    o_tunnel_reply <= 1'b1;
                end
                default: tun_q <= T_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Received byte stream and tunnel data pacing.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rx_byte   <= 8'h00;
            o_rx_valid  <= 1'b0;
            o_tunnel_rd <= 1'b0;
            o_sda_out   <= 1'b0;
            o_sda_oe_n  <= 1'b1;
        end else begin
            o_rx_valid  <= byte_in;
            o_rx_byte   <= byte_in ? rx_next : o_rx_byte;
            o_tunnel_rd <= (bus_q == S_TX_ACK) && scl_rise && !sda_s && rw_q
                           && cmd_q == C_READY && resp_q == RESP_QUERY
                           && tx_idx_q >= 8'h03;
            o_sda_out   <= 1'b0;
            o_sda_oe_n  <= oe_n_q;
        end
    end
endmodule : rfid_host_irq_tunnel_port
`default_nettype wire

//--- rfid_host_irq_tunnel_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rfid_port_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    input wire logic o_irq_low_out_n,
    input wire logic i_tunnel_mode,
    input wire logic i_tunnel_cmd,
    input wire logic i_proc_done,
    input wire logic o_rx_valid,
    input wire logic o_cmd_start,
    input wire logic o_tunnel_reply,
    input wire logic o_tunnel_abort
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence irq_soon; ##[1:6] !o_irq_low_out_n; endsequence
    a_reset_quiet: assert property (
        disable iff (1'b0) !i_rst_n |=> o_irq_low_out_n && o_sda_oe_n) else $error("reset");
    a_sda_open: assert property (o_sda_out == 1'b0) else $error("sda high");
    a_done_irq: assert property (i_proc_done |-> irq_soon) else $error("done irq");
    a_tunnel_irq: assert property (
        i_tunnel_cmd && i_tunnel_mode |-> irq_soon) else $error("tunnel irq");
    a_rx_pulse: assert property (o_rx_valid |=> !o_rx_valid) else $error("rx");
    a_cmd_pulse: assert property (o_cmd_start |=> !o_cmd_start) else $error("start");
    a_reply_pulse: assert property (
        o_tunnel_reply |=> !o_tunnel_reply) else $error("reply");
    a_abort_pulse: assert property (
        o_tunnel_abort |=> !o_tunnel_abort) else $error("abort");
endmodule : rfid_port_checker
bind rfid_host_irq_tunnel_port rfid_port_checker chk (.*);
`default_nettype wire

//--- host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    output logic      o_scl,
    output logic      o_sda_low,
    input  wire logic i_sda
);
    initial o_scl = 1'b1;
    initial o_sda_low = 1'b0;
    task automatic start_bit;
        #200 o_sda_low = 1'b1;
        #200 o_scl = 1'b0;
    endtask : start_bit
    task automatic stop_bit;
        o_sda_low = 1'b1;
        #200 o_scl = 1'b1;
        #200 o_sda_low = 1'b0;
        #400;
    endtask : stop_bit
    // Bits leave MSB first and the ninth slot carries the acknowledge.
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            o_sda_low = (i < 0) ? ack_in : !tx[i];
            #200 o_scl = 1'b1;
            #100 if (i >= 0) rx[i] = i_sda;
            ack = !i_sda;
            #100 o_scl = 1'b0;
        end
    endtask : xfer
endmodule : host_bus_model
`default_nettype wire

//--- tb_rfid_host_irq_tunnel_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rfid_host_irq_tunnel_port;
    localparam logic [6:0] ADDR = 7'h2a;
    logic i_clk, i_rst_n, i_scl, i_sda, sda_low, o_sda_out, o_sda_oe_n, o_irq_low_out_n, ack;
    logic i_contact_supply, i_field_present, i_rf_resp_start, i_rf_nvm_done, i_self_diag_err;
    logic i_rf_busy;
    logic i_tunnel_mode, i_tunnel_cmd, i_proc_done, o_rx_valid, o_cmd_start, o_tunnel_rd;
    logic o_tunnel_reply, o_tunnel_reply_ok, o_tunnel_abort, o_rf_stop, o_reset_req, ok_seen;
    logic [1:0] i_tunnel_sec;
    logic [2:0] i_hw_config_word;
    logic [3:0] i_proc_result;
    logic [7:0] i_query_wait_limit, i_tunnel_len, i_tunnel_data, o_rx_byte, rx, exp_q[$];
    logic [7:0] i_answer_wait_limit;
    logic [11:0] i_tunnel_addr;
    int bad_count, checked, cycles, replies, aborts, seed, resets, tunnel_reads;
    assign i_sda = !sda_low && o_sda_oe_n;
    host_bus_model host (.o_scl(i_scl), .o_sda_low(sda_low), .i_sda(i_sda));
    rfid_host_irq_tunnel_port #(.SLAVE_ADDR(ADDR), .TICK_CYC(20)) uut (.i_bcc_error(1'b1), .*);
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = !i_clk;
    end
    always @(negedge i_clk) begin
        cycles++;
        if (o_reset_req === 1'b1) resets++;
        if (o_tunnel_rd === 1'b1) tunnel_reads++;
        if (o_tunnel_reply === 1'b1) replies++;
        if (o_tunnel_reply === 1'b1) ok_seen = o_tunnel_reply_ok;
        if (o_tunnel_abort === 1'b1) aborts++;
        if (cycles == 40000) begin
            bad_count++;
            stop_test();
        end
    end
    always @(negedge i_clk) i_proc_done <= o_cmd_start;
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge i_clk);
        s = 1'b0;
        repeat (8) @(negedge i_clk);
    endtask : pulse
    task automatic send(input logic [6:0] a, input logic [7:0] b0, b1, input int n);
        host.start_bit();
        host.xfer({a, 1'b0}, 1'b0, rx, ack);
        cmp(8'(ack), 8'(a == ADDR));
        for (int i = 0; i < n; i++) begin
            host.xfer(i ? b1 : b0, 1'b0, rx, ack);
            cmp(8'(ack), 8'h01);
        end
        host.stop_bit();
        @(negedge i_clk);
        if (n > 0) cmp(o_rx_byte, (n > 1) ? b1 : b0);
    endtask : send
    task automatic fetch(input logic irq);
        for (int w = 0; w < 60 && irq && o_irq_low_out_n; w++) @(negedge i_clk);
        cmp(8'(o_irq_low_out_n), 8'(!irq));
        host.start_bit();
        host.xfer({ADDR, 1'b1}, 1'b0, rx, ack);
        cmp(8'(o_irq_low_out_n), 8'h01);
        while (exp_q.size() > 0) begin
            host.xfer(8'hff, exp_q.size() > 1, rx, ack);
            cmp(rx, exp_q.pop_front());
        end
        host.stop_bit();
        repeat (6) @(negedge i_clk);
    endtask : fetch
    task automatic stop_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial begin
        seed = 51951;
        {i_rst_n, i_hw_config_word, i_field_present, i_rf_resp_start, i_rf_nvm_done} = '0;
        {i_self_diag_err, i_rf_busy, i_tunnel_mode, i_tunnel_cmd, i_proc_done, i_tunnel_sec} = '0;
        {i_tunnel_addr, i_tunnel_len, i_tunnel_data, i_proc_result} = $random(seed);
        {i_query_wait_limit, i_answer_wait_limit, i_contact_supply} = 17'h1ffff;
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_clk);
        exp_q = '{8'h00};
        fetch(1'b0);
        send(ADDR ^ 7'h01, 8'h00, 8'h00, 0);
        send(ADDR, 8'h78, 8'h70, 2);
        exp_q = '{8'h00};
        fetch(1'b1);
        {i_hw_config_word, i_field_present} = 4'hb;
        pulse(i_rf_resp_start);
        cmp(8'(o_irq_low_out_n), 8'h01);
        send(ADDR, 8'h68, 8'h00, 1);
        exp_q = '{8'h00, 8'h79};
        fetch(1'b1);
        cmp(8'(o_rf_stop), 8'h01);
        i_self_diag_err = 1'b1;
        exp_q = '{8'h0b};
        fetch(1'b0);
        {i_self_diag_err, i_rf_busy} = 2'b01;
        exp_q = '{8'h07};
        fetch(1'b0);
        i_rf_busy = 1'b0;
        send(ADDR, 8'h78, 8'h01, 2);
        exp_q = '{8'h00};
        fetch(1'b1);
        cmp(8'(resets), 8'h01);
        for (int k = 0; k < 4; k++) begin
            i_hw_config_word = {1'b1, k[1], 1'b0};
            if (k[0]) pulse(i_rf_nvm_done);
            else pulse(i_rf_resp_start);
            exp_q = '{8'h00};
            fetch(k[1] == k[0]);
        end
        {i_hw_config_word, i_field_present} = 4'h2;
        repeat (8) @(negedge i_clk);
        i_field_present = 1'b1;
        exp_q = '{8'h00};
        fetch(1'b1);
        {i_hw_config_word, i_contact_supply, i_field_present} = '0;
        repeat (8) @(negedge i_clk);
        i_field_present = 1'b1;
        repeat (8) @(negedge i_clk);
        cmp(8'(o_irq_low_out_n), 8'h00);
        i_field_present = 1'b0;
        repeat (8) @(negedge i_clk);
        cmp(8'(o_irq_low_out_n), 8'h01);
        $display("interrupt tests done");
        i_contact_supply = 1'b1;
        send(ADDR, 8'h18, 8'h00, 1);
        exp_q = '{{4'h0, i_proc_result}};
        fetch(1'b1);
        send(ADDR, 8'h28, 8'h00, 1);
        exp_q = '{8'h01};
        fetch(1'b1);
        i_tunnel_mode = 1'b1;
        for (int k = 0; k < 4; k++) begin
            i_tunnel_sec = k[1:0];
            pulse(i_tunnel_cmd);
            cmp(8'(o_irq_low_out_n), 8'h00);
            send(ADDR, 8'h28, 8'h00, 1);
            exp_q = '{8'h00, {2'b01, i_tunnel_sec, i_tunnel_addr[11:8]}, i_tunnel_addr[7:0],
                      i_tunnel_len, i_tunnel_data};
            fetch(1'b1);
            cmp(8'(tunnel_reads), 8'(k + 1));
            send(ADDR, k[0] ? 8'he8 : 8'hf8, 8'h5a, 2);
            cmp(8'(replies), 8'(k));
            exp_q = '{8'h00};
            fetch(1'b1);
            cmp(8'(replies), 8'(k + 1));
            cmp(8'(ok_seen), 8'(!k[0]));
        end
        $display("tunnel exchange tests done");
        i_query_wait_limit = 8'h02;
        pulse(i_tunnel_cmd);
        cmp(8'(aborts), 8'h00);
        repeat (80) @(negedge i_clk);
        cmp(8'(aborts), 8'h01);
        {i_query_wait_limit, i_answer_wait_limit} = 16'hff02;
        pulse(i_tunnel_cmd);
        send(ADDR, 8'h28, 8'h00, 1);
        exp_q = '{8'h00, {2'b01, i_tunnel_sec, i_tunnel_addr[11:8]}, i_tunnel_addr[7:0],
                  i_tunnel_len, i_tunnel_data};
        fetch(1'b1);
        cmp(8'(aborts), 8'h01);
        repeat (80) @(negedge i_clk);
        cmp(8'(aborts), 8'h02);
        $display("timeout test done");
        stop_test();
    end
endmodule : tb_rfid_host_irq_tunnel_port
`default_nettype wire
